// ---- core/sgc_regs.svh ----
// register offsets, field positions, reset values and timing counts of the global config bank
`ifndef SGC_REGS_SVH
`define SGC_REGS_SVH

// ==========================================================
// frame layout
`define SGC_FRAME_BITS        40
`define SGC_ADDR_BITS         8
`define SGC_DATA_BITS         32
`define SGC_WRITE_FLAG        8'h80
`define SGC_WRITE_BIT         7

// ==========================================================
// register offsets
`define SGC_ADDR_GLOBAL_CONFIG 7'h00
`define SGC_ADDR_EVENT_FLAGS   7'h01
`define SGC_ADDR_INPUT_STATE   7'h04
`define SGC_ADDR_CURRENTS      7'h10

// ==========================================================
// global_config fields
`define SGC_GC_WIDTH           18
`define SGC_GC_ZERO_CROSS_RECAL 0
`define SGC_GC_SHORT_STST      1
`define SGC_GC_PWM_MODE        2
`define SGC_GC_STEP_FILTER     3
`define SGC_GC_DIR_INVERT      4
`define SGC_GC_DIAG_OUT0_FAULT     5
`define SGC_GC_RESET           18'h00008

// ==========================================================
// event flag fields, clear by writing one
`define SGC_EV_WIDTH           3
`define SGC_EV_RESET_SEEN      0
`define SGC_EV_DRV_ERR         1
`define SGC_EV_STANDSTILL      2
`define SGC_EV_RESET           3'h1

// ==========================================================
// input state fields, read only
`define SGC_IN_WIDTH           6

// ==========================================================
// currents register, write only
`define SGC_CUR_WIDTH          5
`define SGC_CUR_HOLD_LSB       0
`define SGC_CUR_RUN_LSB        8
`define SGC_CUR_RESET          5'h00

// ==========================================================
// standstill timeout, in device clocks
`define SGC_STST_SHORT_CLOCKS  262144
`define SGC_STST_LONG_CLOCKS   1048576
`define SGC_STST_CNT_WIDTH     21

// ==========================================================
// step filter: samples a step level must hold
`define SGC_STEP_FILT_SAMPLES  3

`endif

// ---- core/sgc_pkg.sv ----
// types shared by the global config bank modules
package sgc_pkg;

  typedef logic [17:0] sgc_global_config_t;

  typedef enum logic [1:0]
  {
    SGC_ACC_NONE = 2'b00,
    SGC_ACC_RW   = 2'b01,
    SGC_ACC_RO   = 2'b10,
    SGC_ACC_WO   = 2'b11
  } sgc_access_t;

endpackage

// ---- core/sgc_frame_if.sv ----
// frame hand-off between the serial shifter and the register core
`timescale 1ns/1ps
interface sgc_frame_if;
  logic        frame_vld;
  logic [7:0]  frame_addr;
  logic [31:0] frame_data;
  logic [39:0] reply;

  modport shifter
  (
    output frame_vld,
    output frame_addr,
    output frame_data,
    input  reply
  );

  modport core
  (
    input  frame_vld,
    input  frame_addr,
    input  frame_data,
    output reply
  );
endinterface

// ---- core/sgc_spi_shifter.sv ----
// serial datagram shifter: 40-bit frames in, previous reply out
`timescale 1ns/1ps
`include "sgc_regs.svh"
module sgc_spi_shifter
  import sgc_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  sys_rst,
  input  wire logic  spi_sck,
  input  wire logic  spi_csn,
  input  wire logic  spi_sdi,
  output logic       spi_sdo,
  output logic       spi_sdo_oe_n,
  sgc_frame_if.shifter fr
);

  // ==========================================================
  // pin synchronisers, stage 0 feeds stage 1 only
  logic [2:0] sck_reg;
  logic [2:0] csn_reg;
  logic [1:0] sdi_reg;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sck_reg <= 3'h7;
      csn_reg <= 3'h7;
      sdi_reg <= 2'h0;
    end
    else
    begin
      sck_reg <= {sck_reg[1:0], spi_sck};
      csn_reg <= {csn_reg[1:0], spi_csn};
      sdi_reg <= {sdi_reg[0], spi_sdi};
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic sel_start;
  logic sel_end;

  assign sck_rise  = sck_reg[1] & ~sck_reg[2];
  assign sck_fall  = ~sck_reg[1] & sck_reg[2];
  assign sel_start = ~csn_reg[1] & csn_reg[2];
  assign sel_end   = csn_reg[1] & ~csn_reg[2];

  // ==========================================================
  // shift engine
  logic [5:0]  cnt_reg,  cnt_next;
  logic [39:0] in_reg,   in_next;
  logic [39:0] out_reg,  out_next;
  logic        sdo_reg,  sdo_next;
  logic        oen_reg,  oen_next;
  logic        vld_reg,  vld_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    in_next  = in_reg;
    out_next = out_reg;
    sdo_next = sdo_reg;
    oen_next = csn_reg[1];
    vld_next = 1'b0;
    if (sel_start)
    begin
      cnt_next = 6'h00;
      out_next = fr.reply;
      sdo_next = fr.reply[39];
    end
    else if (!csn_reg[1])
    begin
      if (sck_rise)
      begin
        in_next = {in_reg[38:0], sdi_reg[1]};
        if (cnt_reg != 6'h3F)
          cnt_next = cnt_reg + 6'h01;
      end
      // mode 3: the first falling edge presents the msb again, every later one the next bit
      if (sck_fall)
      begin
        out_next = {out_reg[38:0], 1'b0};
        sdo_next = out_reg[39];
      end
    end
    // a frame of any other length is dropped whole
    if (sel_end && cnt_reg == 6'(`SGC_FRAME_BITS))
      vld_next = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 6'h00;
      in_reg  <= 40'h00_0000_0000;
      out_reg <= 40'h00_0000_0000;
      sdo_reg <= 1'b0;
      oen_reg <= 1'b1;
      vld_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      in_reg  <= in_next;
      out_reg <= out_next;
      sdo_reg <= sdo_next;
      oen_reg <= oen_next;
      vld_reg <= vld_next;
    end
  end

  assign spi_sdo       = sdo_reg;
  assign spi_sdo_oe_n  = oen_reg;
  assign fr.frame_vld  = vld_reg;
  assign fr.frame_addr = in_reg[39:32];
  assign fr.frame_data = in_reg[31:0];

endmodule

// ---- core/sgc_standstill_timer.sv ----
// counts clocks since the last executed step and flags standstill
`timescale 1ns/1ps
`include "sgc_regs.svh"
module sgc_standstill_timer
#(
  parameter int unsigned SHORT_CYC = `SGC_STST_SHORT_CLOCKS,
  parameter int unsigned LONG_CYC  = `SGC_STST_LONG_CLOCKS,
  parameter int unsigned CW        = `SGC_STST_CNT_WIDTH
)
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic step_pulse,
  input  wire logic short_sel,
  output logic      standstill
);

  logic [CW-1:0] limit;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          st_reg,  st_next;

  assign limit = short_sel ? CW'(SHORT_CYC) : CW'(LONG_CYC);

  always_comb
  begin
    cnt_next = cnt_reg;
    st_next  = st_reg;
    if (step_pulse)
    begin
      cnt_next = '0;
      st_next  = 1'b0;
    end
    // compare with >= so a switch to the short timeout takes effect at once
    else if (cnt_reg >= limit - CW'(1))
      st_next = 1'b1;
    else
      cnt_next = cnt_reg + CW'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_reg <= '0;
      st_reg  <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      st_reg  <= st_next;
    end
  end

  assign standstill = st_reg;

endmodule

// ---- core/sgc_top.sv ----
// global configuration register bank of the stepper controller
`timescale 1ns/1ps
`include "sgc_regs.svh"
// ==========================================================
module sgc_top
  import sgc_pkg::*;
#(
  parameter int unsigned STST_SHORT_CYC = `SGC_STST_SHORT_CLOCKS,
  parameter int unsigned STST_LONG_CYC  = `SGC_STST_LONG_CLOCKS
)
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       spi_sck,
  input  wire logic       spi_csn,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  output logic            spi_sdo_oe_n,
  input  wire logic       step_in,
  input  wire logic       dir_in,
  input  wire logic       driver_disable_pin,
  input  wire logic       step_dir_select,
  input  wire logic       overtemp_flag,
  input  wire logic       short_ground_flag,
  input  wire logic [3:0] off_time_setting,
  output logic            step_exec,
  output logic            motor_dir,
  output logic            zero_cross_recal_active,
  output logic            standstill,
  output logic            pwm_mode_en,
  output logic            step_input_filter_en,
  output logic [4:0]      standstill_current,
  output logic [4:0]      run_current,
  output logic            diag_out0_o,
  output logic            diag_out0_oe_n
);

  sgc_frame_if fr ();

  sgc_spi_shifter u_shift
  (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .spi_sck      (spi_sck),
    .spi_csn      (spi_csn),
    .spi_sdi      (spi_sdi),
    .spi_sdo      (spi_sdo),
    .spi_sdo_oe_n (spi_sdo_oe_n),
    .fr           (fr.shifter)
  );

  // ==========================================================
  // pin synchronisers; stage 0 is read only by stage 1
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s0_reg;
  logic [NPIN-1:0] pin_s1_reg;

  assign pin_raw = {short_ground_flag, overtemp_flag, step_dir_select,
                    driver_disable_pin, dir_in, step_in};

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pin_s0_reg <= 6'h00;
      pin_s1_reg <= 6'h00;
    end
    else
    begin
      pin_s0_reg <= pin_raw;
      pin_s1_reg <= pin_s0_reg;
    end
  end

  logic step_s;
  logic dir_s;
  logic drv_dis_s;
  logic sd_sel_s;
  logic drv_err_s;

  assign step_s    = pin_s1_reg[0];
  assign dir_s     = pin_s1_reg[1];
  assign drv_dis_s = pin_s1_reg[2];
  assign sd_sel_s  = pin_s1_reg[3];
  assign drv_err_s = pin_s1_reg[4] | pin_s1_reg[5];

  // ==========================================================
  // register access decode
  logic        is_write;
  logic [6:0]  reg_addr;
  sgc_access_t acc;

  assign is_write = fr.frame_addr[`SGC_WRITE_BIT];
  assign reg_addr = fr.frame_addr[6:0];

  always_comb
  begin
    unique case (reg_addr)
      `SGC_ADDR_GLOBAL_CONFIG: acc = SGC_ACC_RW;
      `SGC_ADDR_EVENT_FLAGS:   acc = SGC_ACC_RW;
      `SGC_ADDR_INPUT_STATE:   acc = SGC_ACC_RO;
      `SGC_ADDR_CURRENTS:      acc = SGC_ACC_WO;
      default:                 acc = SGC_ACC_NONE;
    endcase
  end

  // ==========================================================
  // register state
  sgc_global_config_t                gc_reg,   gc_next;
  logic [`SGC_EV_WIDTH-1:0]  ev_reg,   ev_next;
  logic [`SGC_CUR_WIDTH-1:0] hold_reg, hold_next;
  logic [`SGC_CUR_WIDTH-1:0] run_reg,  run_next;
  logic [31:0]               rd_reg,   rd_next;
  logic                      wr_ev;
  logic                      err_seen_reg;
  logic                      stst_seen_reg;
  logic                      stst_w;
  logic [`SGC_EV_WIDTH-1:0]  ev_set;
  logic [`SGC_IN_WIDTH-1:0]  in_state;

  assign wr_ev  = fr.frame_vld && is_write && reg_addr == `SGC_ADDR_EVENT_FLAGS;
  assign ev_set = {stst_w & ~stst_seen_reg, drv_err_s & ~err_seen_reg, 1'b0};
  assign in_state = {stst_w, drv_err_s, sd_sel_s, drv_dis_s, dir_s, step_s};

  always_comb
  begin
    gc_next   = gc_reg;
    hold_next = hold_reg;
    run_next  = run_reg;
    rd_next   = rd_reg;
    ev_next   = ev_reg;
    if (wr_ev)
      ev_next = ev_reg & ~fr.frame_data[`SGC_EV_WIDTH-1:0];
    // a new event wins over a clear in the same cycle
    ev_next = ev_next | ev_set;
    if (fr.frame_vld && is_write)
    begin
      // read-only and unmapped addresses drop writes
      if (reg_addr == `SGC_ADDR_GLOBAL_CONFIG)
        gc_next = fr.frame_data[`SGC_GC_WIDTH-1:0];
      if (reg_addr == `SGC_ADDR_CURRENTS)
      begin
        hold_next = fr.frame_data[`SGC_CUR_HOLD_LSB +: `SGC_CUR_WIDTH];
        run_next  = fr.frame_data[`SGC_CUR_RUN_LSB +: `SGC_CUR_WIDTH];
      end
    end
    // the reply of any frame carries the data asked for by the previous one
    if (fr.frame_vld)
    begin
      rd_next = 32'h0000_0000;
      if (!is_write)
      begin
        unique case (acc)
          SGC_ACC_RW:
          begin
            if (reg_addr == `SGC_ADDR_GLOBAL_CONFIG)
              rd_next = {14'h0000, gc_reg};
            else
              rd_next = {29'h0000_0000, ev_reg};
          end
          SGC_ACC_RO:   rd_next = {26'h000_0000, in_state};
          SGC_ACC_WO:   rd_next = 32'h0000_0000;
          SGC_ACC_NONE: rd_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      gc_reg   <= `SGC_GC_RESET;
      ev_reg   <= `SGC_EV_RESET;
      hold_reg <= `SGC_CUR_RESET;
      run_reg  <= `SGC_CUR_RESET;
      rd_reg   <= 32'h0000_0000;
    end
    else
    begin
      gc_reg   <= gc_next;
      ev_reg   <= ev_next;
      hold_reg <= hold_next;
      run_reg  <= run_next;
      rd_reg   <= rd_next;
    end
  end

  assign fr.reply = {{5'h00, ev_reg}, rd_reg};

  // ==========================================================
  // step input filter and direction
  logic [`SGC_STEP_FILT_SAMPLES-1:0] fhist_reg, fhist_next;
  logic step_lvl_reg, step_lvl_next;
  logic step_pulse;

  always_comb
  begin
    fhist_next    = {fhist_reg[`SGC_STEP_FILT_SAMPLES-2:0], step_s};
    step_lvl_next = step_lvl_reg;
    // the filter costs a few clocks of latency for glitch immunity
    if (!gc_reg[`SGC_GC_STEP_FILTER])
      step_lvl_next = step_s;
    else if (&fhist_reg)
      step_lvl_next = 1'b1;
    else if (~|fhist_reg)
      step_lvl_next = 1'b0;
  end

  assign step_pulse = step_lvl_next & ~step_lvl_reg;

  logic dir_reg, dir_next;
  logic recal_reg, recal_next;
  logic pwm_reg, pwm_next;
  logic filt_reg, filt_next;
  logic stp_reg;
  logic diag_reg, diag_next;

  always_comb
  begin
    dir_next   = dir_s ^ gc_reg[`SGC_GC_DIR_INVERT];
    recal_next = gc_reg[`SGC_GC_ZERO_CROSS_RECAL]
                 && (drv_dis_s || off_time_setting == 4'h0);
    pwm_next   = gc_reg[`SGC_GC_PWM_MODE];
    filt_next  = gc_reg[`SGC_GC_STEP_FILTER];
    // open collector, active low: drive low on fault while step_dir_select is high and SGC_GC_DIAG_OUT0_FAULT is set
    diag_next  = sd_sel_s && gc_reg[`SGC_GC_DIAG_OUT0_FAULT] && drv_err_s;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fhist_reg    <= '0;
      step_lvl_reg <= 1'b0;
      dir_reg      <= 1'b0;
      recal_reg    <= 1'b0;
      pwm_reg      <= 1'b0;
      filt_reg     <= 1'b1;
      stp_reg      <= 1'b0;
      diag_reg     <= 1'b1;
    end
    else
    begin
      fhist_reg    <= fhist_next;
      step_lvl_reg <= step_lvl_next;
      dir_reg      <= dir_next;
      recal_reg    <= recal_next;
      pwm_reg      <= pwm_next;
      filt_reg     <= filt_next;
      stp_reg      <= step_pulse;
      diag_reg     <= diag_next;
    end
  end

  // ==========================================================
  // standstill detection and event latches
  sgc_standstill_timer
  #(
    .SHORT_CYC (STST_SHORT_CYC),
    .LONG_CYC  (STST_LONG_CYC),
    .CW        (`SGC_STST_CNT_WIDTH)
  )
  u_stst
  (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .step_pulse (step_pulse),
    .short_sel  (gc_reg[`SGC_GC_SHORT_STST]),
    .standstill (stst_w)
  );

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      err_seen_reg  <= 1'b0;
      stst_seen_reg <= 1'b0;
    end
    else
    begin
      err_seen_reg  <= drv_err_s;
      stst_seen_reg <= stst_w;
    end
  end

  assign step_exec               = stp_reg;
  assign motor_dir               = dir_reg;
  assign zero_cross_recal_active = recal_reg;
  assign standstill              = stst_w;
  assign pwm_mode_en             = pwm_reg;
  assign step_input_filter_en    = filt_reg;
  assign standstill_current      = hold_reg;
  assign run_current             = run_reg;
  assign diag_out0_o             = 1'b0;
  assign diag_out0_oe_n          = ~diag_reg;

endmodule

// ---- tb/sgc_host_model.sv ----
// host model driving the 40-bit serial frames of the config bank
`timescale 1ns/1ps
module sgc_host_model
(
  input  wire logic ref_clk,
  input  wire logic spi_sdo,
  output logic      spi_sck,
  output logic      spi_csn,
  output logic      spi_sdi
);
  // ==========================================================
  // serial master
  initial
  begin
    spi_sck = 1'b1;
    spi_csn = 1'b1;
    spi_sdi = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  // mode 3, msb first; rx carries the reply to the previous frame
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    spi_csn = 1'b0;
    cyc(4);
    for (int i = 39; i >= 0; i--)
    begin
      spi_sck = 1'b0;
      spi_sdi = tx[i];
      cyc(5);
      spi_sck = 1'b1;
      rx[i] = spi_sdo;
      cyc(5);
    end
    spi_csn = 1'b1;
    // released line must not keep looking like valid data
    spi_sdi = ~spi_sdi;
    cyc(10);
  endtask
endmodule

// ---- tb/sgc_top_chk.sv ----
// port assertions for the global config bank
`timescale 1ns/1ps
module sgc_top_chk
#(
  parameter int unsigned STST_SHORT_CYC = 262144,
  parameter int unsigned STST_LONG_CYC  = 1048576
)
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       spi_csn,
  input wire logic       driver_disable_pin,
  input wire logic       step_dir_select,
  input wire logic       overtemp_flag,
  input wire logic       short_ground_flag,
  input wire logic [3:0] off_time_setting,
  input wire logic       step_exec,
  input wire logic       zero_cross_recal_active,
  input wire logic       standstill,
  input wire logic       pwm_mode_en,
  input wire logic       step_input_filter_en,
  input wire logic [4:0] standstill_current,
  input wire logic [4:0] run_current,
  input wire logic       diag_out0_oe_n
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [20:0] idle_cnt;
  always_ff @(posedge ref_clk)
    idle_cnt <= (sys_rst || step_exec) ? 21'h0 : idle_cnt + 21'h1;

  // ==========================================================
  // properties
  property p_rst_diag;
    disable iff (1'b0) sys_rst |=> !diag_out0_oe_n;
  endproperty
  a_rst_diag: assert property (p_rst_diag) else $error("diag not low in reset");
  property p_rst_filt;
    disable iff (1'b0) sys_rst |=> step_input_filter_en;
  endproperty
  a_rst_filt: assert property (p_rst_filt) else $error("filter not set in reset");
  property p_rst_zero;
    disable iff (1'b0) sys_rst |=> !pwm_mode_en && !standstill && !zero_cross_recal_active
      && standstill_current == 5'h00 && run_current == 5'h00;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("output not zero in reset");
  property p_diag_sel;
    !step_dir_select [*6] |=> diag_out0_oe_n;
  endproperty
  a_diag_sel: assert property (p_diag_sel) else $error("diag active without select");
  property p_diag_ok;
    (!overtemp_flag && !short_ground_flag) [*6] |=> diag_out0_oe_n;
  endproperty
  a_diag_ok: assert property (p_diag_ok) else $error("diag active without fault");
  property p_recal;
    (!driver_disable_pin && off_time_setting != 4'h0) [*6] |=> !zero_cross_recal_active;
  endproperty
  a_recal: assert property (p_recal) else $error("recal while driver enabled");
  property p_cfg_hold;
    !spi_csn [*8] |=> $stable({pwm_mode_en, step_input_filter_en, standstill_current,
      run_current});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved mid frame");
  property p_step_clr;
    step_exec |-> ##[1:2] !standstill;
  endproperty
  a_step_clr: assert property (p_step_clr) else $error("step left standstill set");
  property p_still_min;
    $rose(standstill) |-> idle_cnt >= STST_SHORT_CYC - 4;
  endproperty
  a_still_min: assert property (p_still_min) else $error("standstill too early");
  property p_still_max;
    idle_cnt == STST_LONG_CYC + 8 |-> standstill;
  endproperty
  a_still_max: assert property (p_still_max) else $error("standstill too late");
endmodule

bind sgc_top sgc_top_chk #(.STST_SHORT_CYC(STST_SHORT_CYC), .STST_LONG_CYC(STST_LONG_CYC))
  u_sgc_top_chk
(
  .ref_clk, .sys_rst, .spi_csn, .driver_disable_pin, .step_dir_select, .overtemp_flag,
  .short_ground_flag, .off_time_setting, .step_exec, .zero_cross_recal_active,
  .standstill, .pwm_mode_en, .step_input_filter_en, .standstill_current, .run_current,
  .diag_out0_oe_n
);

// ---- tb/test_sgc_top.sv ----
// self-checking testbench of the global config bank
`timescale 1ns/1ps
module test_sgc_top;
  localparam int unsigned SHORT = 64;
  localparam int unsigned LONG  = 256;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        spi_sck, spi_csn, spi_sdi, spi_sdo, spi_sdo_oe_n;
  logic        step_in = 1'b0, dir_in = 1'b0, driver_disable_pin = 1'b0;
  logic        step_dir_select = 1'b0, overtemp_flag = 1'b0, short_ground_flag = 1'b0;
  logic [3:0]  off_time_setting = 4'h5;
  logic        step_exec, motor_dir, zero_cross_recal_active, standstill, pwm_mode_en;
  logic        step_input_filter_en, diag_out0_o, diag_out0_oe_n;
  logic [4:0]  standstill_current, run_current;
  logic [39:0] rx;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #12.5 ref_clk = ~ref_clk;

  sgc_top #(.STST_SHORT_CYC(SHORT), .STST_LONG_CYC(LONG)) u_sgc_top
  (
    .ref_clk, .sys_rst, .spi_sck, .spi_csn, .spi_sdi, .spi_sdo, .spi_sdo_oe_n,
    .step_in, .dir_in, .driver_disable_pin, .step_dir_select, .overtemp_flag,
    .short_ground_flag, .off_time_setting, .step_exec, .motor_dir,
    .zero_cross_recal_active, .standstill, .pwm_mode_en, .step_input_filter_en,
    .standstill_current, .run_current, .diag_out0_o, .diag_out0_oe_n
  );

  sgc_host_model u_host (.ref_clk, .spi_sdo, .spi_sck, .spi_csn, .spi_sdi);

  // ==========================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    u_host.xfer({1'b1, a, d}, rx);
  endtask

  // the reply lags one frame, so a dummy read fetches it
  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    u_host.xfer({1'b0, a, 32'h0}, rx);
    u_host.xfer(40'h0, rx);
    chk(rx[31:0], exp);
  endtask

  task automatic do_reset;
    sys_rst = 1'b1;
    cyc(3);
    chk(diag_out0_oe_n, 1'b0);
    chk(spi_sdo_oe_n, 1'b1);
    cyc(7);
    sys_rst = 1'b0;
    cyc(4);
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(7'h00, 32'h8);
    chk(step_input_filter_en, 1'b1);
    chk({pwm_mode_en, zero_cross_recal_active, standstill_current, run_current}, 12'h000);
    done("reset");
  endtask

  task automatic t_flags;
    rd(7'h01, 32'h5);
    chk(rx[39:32], 8'h05);
    wr(7'h01, 32'h0);
    rd(7'h01, 32'h5);
    wr(7'h01, 32'h1);
    rd(7'h01, 32'h4);
    wr(7'h01, 32'h4);
    rd(7'h01, 32'h0);
    done("flags");
  endtask

  task automatic t_global_config;
    wr(7'h00, 32'h18);
    chk(motor_dir, 1'b1);
    dir_in = 1'b1;
    cyc(8);
    chk(motor_dir, 1'b0);
    u_host.xfer({8'h00, 32'h3FFFF}, rx);
    rd(7'h00, 32'h18);
    wr(7'h00, 32'hFFFFFFFF);
    rd(7'h00, 32'h3FFFF);
    wr(7'h00, 32'h8);
    done("global_config");
  endtask

  task automatic t_access;
    wr(7'h10, 32'h00000A0A);
    chk({standstill_current, run_current}, 10'h14A);
    rd(7'h10, 32'h0);
    wr(7'h04, 32'hFFFFFFFF);
    rd(7'h04, 32'h22);
    rd(7'h7F, 32'h0);
    chk(standstill, 1'b1);
    wr(7'h00, 32'hC);
    chk(pwm_mode_en, 1'b1);
    wr(7'h00, 32'h8);
    chk(pwm_mode_en, 1'b0);
    done("access");
  endtask

  task automatic t_still(input logic s, input int n);
    int c;
    wr(7'h00, {28'h0, 2'b10, s, 1'b0});
    step_in = 1'b1;
    c = 0;
    repeat (8)
    begin
      cyc(1);
      if (step_exec === 1'b1)
        c++;
    end
    chk(c, 1);
    step_in = 1'b0;
    c = 0;
    while (standstill !== 1'b1 && c < 2 * n)
    begin
      cyc(1);
      c++;
    end
    chk(c > n - 16 && c < n + 16, 1'b1);
    done("standstill");
  endtask

  task automatic t_recal;
    wr(7'h00, 32'h9);
    chk(zero_cross_recal_active, 1'b0);
    driver_disable_pin = 1'b1;
    cyc(6);
    chk(zero_cross_recal_active, 1'b1);
    driver_disable_pin = 1'b0;
    off_time_setting = 4'h0;
    cyc(6);
    chk(zero_cross_recal_active, 1'b1);
    wr(7'h00, 32'h8);
    chk(zero_cross_recal_active, 1'b0);
    off_time_setting = 4'h5;
    done("recal");
  endtask

  task automatic t_diag;
    wr(7'h00, 32'h28);
    step_dir_select = 1'b1;
    overtemp_flag = 1'b1;
    cyc(8);
    chk({diag_out0_oe_n, diag_out0_o}, 2'b00);
    overtemp_flag = 1'b0;
    short_ground_flag = 1'b1;
    cyc(8);
    chk(diag_out0_oe_n, 1'b0);
    step_dir_select = 1'b0;
    cyc(8);
    chk(diag_out0_oe_n, 1'b1);
    step_dir_select = 1'b1;
    short_ground_flag = 1'b0;
    cyc(8);
    chk(diag_out0_oe_n, 1'b1);
    wr(7'h00, 32'h14);
    do_reset();
    rd(7'h00, 32'h8);
    done("diag");
  endtask

  initial
  begin
    #1_000_000;
    n_fail++;
    end_sim();
  end

  initial
  begin
    do_reset();
    t_reset();
    t_flags();
    t_global_config();
    t_access();
    t_still(1'b1, SHORT);
    t_still(1'b0, LONG);
    t_recal();
    t_diag();
    end_sim();
  end
endmodule
